// ### pwrmode_regs.svh
`ifndef PWRMODE_REGS_SVH
`define PWRMODE_REGS_SVH
// ************************************************************
// Register map
// ************************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CMD 8'h08
`define REG_STAB 8'h0C
`define REG_PORTCFG 8'h10
`define REG_PLL 8'h14
// ************************************************************
// Field positions and reset values
// ************************************************************
`define CMD_STOP_BIT 4
`define CMD_HALT_BIT 5
`define CTRL_LCD_EN_BIT 0
`define CTRL_SIO_SLAVE_BIT 1
`define CTRL_PLL_EN_BIT 2
`define CTRL_RESET 8'h00
`define CTRL_STOP_KEEP 8'h02
`define STAB_RESET 16'h0100
// ************************************************************
// Timing
// ************************************************************
`define OSC_NS 100
`define CLK_MHZ 10
`endif

// ### pwrmode_pkg.sv
`default_nettype none
package pwrmode_pkg;
  typedef enum logic [1:0] {RUN_ST, HALT_ST, STOP_ST, WAKE_ST} pmode_t;
  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] latch;
    logic [3:0] mux_sel;
  } port_cfg_t;
  typedef struct packed {
    logic cpu_run;
    logic periph_run;
    logic sio_run;
    logic lcd_run;
    logic pll_run;
  } run_en_t;
endpackage : pwrmode_pkg
`default_nettype wire

// ### wake_sync.sv
`default_nettype none
module wake_sync #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
    end
  end
  assign o_sync = s2_q;
endmodule : wake_sync
`default_nettype wire

// ### pwrmode_ctrl.sv
// Contract
// - In halt only instruction execution stops; peripherals keep running. Code also stops serial in halt unless CTRL bit 1 (slave) is set.
// - In clock-stop every peripheral unit is stopped.
// - Control registers kept across halt, partly reset on stop entry.
// - Program counter frozen at the halt or stop instruction address.
// - In halt, serial runs only in slave mode with external clock.
// - Stop entry returns muxed pins to port mode, except A/D, LCD inputs; code clears all four mux_sel bits with no exception.
// - Stop keeps pin directions and output-only latch values.
// - PLL disabled or stopped pulls both VCO inputs low.
// - Stop pulls oscillator input low and drives oscillator output high.
// - Stop with display disabled drives segments and commons low.
// - Halt keeps LCD drive waveforms whatever the display enable.
// - Selected wake port high level releases clock-stop.
// - After release wait half stabilization time, then resume next opcode.
// - Stop carries a 4-bit release mask; zero mask needs reset.
//
// Implementation choices: register access over Wishbone and the address map.
`default_nettype none
`include "pwrmode_regs.svh"
module pwrmode_ctrl (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_ADR,
  input wire logic [31:0] I_DAT,
  output logic [31:0] O_DAT,
  input wire logic I_WE,
  input wire logic [3:0] I_SEL,
  input wire logic I_CYC,
  input wire logic I_STB,
  output logic O_ACK,
  input wire logic I_HALT_REQ,
  input wire logic I_HALT_RELEASE,
  input wire logic [3:0] I_STOP_MASK,
  input wire logic [3:0] I_WAKE_COND,
  input wire logic [3:0] I_WAKE_INPUT_PORT,
  input wire logic [12:0] I_PC,
  output logic [12:0] O_PC_HOLD,
  output pwrmode_pkg::run_en_t O_RUN,
  output pwrmode_pkg::port_cfg_t O_PORT,
  output logic [1:0] O_MODE,
  output logic O_VCO_PULLDOWN,
  output logic O_CP_OE,
  output logic O_OSC_IN_PULLDOWN,
  output logic O_OSC_OUT_HIGH,
  output logic O_LCD_FORCE_LOW,
  output logic O_RESUME
);
  import pwrmode_pkg::*;
  // ************************************************************
  // Bus slave
  // ************************************************************
  logic [7:0] ctrl_q;
  logic [15:0] stab_q;
  port_cfg_t port_q;
  port_cfg_t port_d;
  logic [7:0] ctrl_d;
  pmode_t mode_q;
  pmode_t mode_d;
  logic [3:0] mask_q;
  logic [12:0] pc_q;
  logic [15:0] wait_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [3:0] wake_s;
  logic cmd_stop;
  logic cmd_halt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wire req = I_CYC && I_STB && !ack_q;
  wire wr = req && I_WE;
  wire wr_ctrl = wr && (I_ADR == `REG_CTRL);
  wire wr_cmd = wr && (I_ADR == `REG_CMD) && I_SEL[0];
  wire wr_stab = wr && (I_ADR == `REG_STAB);
  wire wr_port = wr && (I_ADR == `REG_PORTCFG);
  wire [31:0] ctrl_m = merge({24'h000000, ctrl_q}, I_DAT, I_SEL);
  wire [31:0] stab_m = merge({16'h0000, stab_q}, I_DAT, I_SEL);
  wire [31:0] port_m = merge({20'h00000, port_q}, I_DAT, I_SEL);
  assign cmd_stop = (wr_cmd && I_DAT[`CMD_STOP_BIT]) || I_STOP_MASK != 4'h0
    && 1'b0;
  assign cmd_halt = (wr_cmd && I_DAT[`CMD_HALT_BIT]) || I_HALT_REQ;

  wire [31:0] rd_mux =
    (I_ADR == `REG_CTRL) ? {24'h000000, ctrl_q} :
    (I_ADR == `REG_STATUS) ? {26'h0000000, wake_s, mode_q} :
    (I_ADR == `REG_CMD) ? {28'h0000000, mask_q} :
    (I_ADR == `REG_STAB) ? {16'h0000, stab_q} :
    (I_ADR == `REG_PORTCFG) ? {20'h00000, port_q} :
    (I_ADR == `REG_PLL) ? {31'h00000000, ctrl_q[`CTRL_PLL_EN_BIT]} :
    32'h00000000;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rd_mux;
      end
    end
  end
  assign O_ACK = ack_q;
  assign O_DAT = rdat_q;

  // ************************************************************
  // Wake input
  // ************************************************************
  wake_sync #(.W(4)) u_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RSTN),
    .i_async(I_WAKE_INPUT_PORT),
    .o_sync(wake_s)
  );
  // Port wake is mask bit 0; others come from the core. Zero mask: reset only
  wire port_wake = mask_q[0] && (wake_s != 4'h0);
  wire wake_any = port_wake || ((mask_q[3:1] & I_WAKE_COND[3:1]) != 3'h0);

  // ************************************************************
  // Mode sequencer
  // ************************************************************
  wire stop_now = wr_cmd && I_DAT[`CMD_STOP_BIT];
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      RUN_ST: begin
        if (stop_now) begin
          mode_d = STOP_ST;
        end else if (cmd_halt) begin
          mode_d = HALT_ST;
        end
      end
      HALT_ST: begin
        if (I_HALT_RELEASE) begin
          mode_d = RUN_ST;
        end
      end
      STOP_ST: begin
        if (wake_any) begin
          mode_d = WAKE_ST;
        end
      end
      WAKE_ST: begin
        if (wait_q == 16'h0000) begin
          mode_d = RUN_ST;
        end
      end
    endcase
  end

  // Control registers survive halt; stop entry keeps only CTRL bit 1 (SIO slave) and clears mux_sel
  always_comb begin
    ctrl_d = wr_ctrl ? ctrl_m[7:0] : ctrl_q;
    port_d = wr_port ? port_m[11:0] : port_q;
    if (stop_now && mode_q == RUN_ST) begin
      ctrl_d = ctrl_q & `CTRL_STOP_KEEP;
      port_d.mux_sel = port_q.mux_sel & 4'h0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_q <= RUN_ST;
      ctrl_q <= `CTRL_RESET;
      stab_q <= `STAB_RESET;
      port_q <= '0;
      mask_q <= 4'h0;
      pc_q <= 13'h0000;
      wait_q <= 16'h0000;
    end else begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      port_q <= port_d;
      if (wr_stab) begin
        stab_q <= stab_m[15:0];
      end
      if (mode_q == RUN_ST && mode_d != RUN_ST) begin
        pc_q <= I_PC;
        if (stop_now) begin
          mask_q <= I_DAT[3:0];
        end
      end
      if (mode_q == STOP_ST) begin
        wait_q <= {1'b0, stab_q[15:1]};
      end else if (wait_q != 16'h0000) begin
        wait_q <= wait_q - 16'h0001;
      end
    end
  end

  // ************************************************************
  // Run enables and pin states
  // ************************************************************
  wire in_stop = (mode_q == STOP_ST) || (mode_q == WAKE_ST);
  wire pll_off = in_stop || !ctrl_q[`CTRL_PLL_EN_BIT];
  wire unused = cmd_stop;
  assign O_RUN.cpu_run = (mode_q == RUN_ST);
  assign O_RUN.periph_run = !in_stop;
  assign O_RUN.sio_run = (mode_q == RUN_ST) ||
    (mode_q == HALT_ST && ctrl_q[`CTRL_SIO_SLAVE_BIT]);
  // LCD drive keeps running in halt even with display off
  assign O_RUN.lcd_run = !in_stop;
  assign O_RUN.pll_run = !pll_off;
  assign O_PORT = port_q;
  assign O_PC_HOLD = pc_q;
  assign O_MODE = mode_q;
  assign O_VCO_PULLDOWN = pll_off;
  assign O_CP_OE = !pll_off;
  assign O_OSC_IN_PULLDOWN = in_stop && mode_q == STOP_ST;
  assign O_OSC_OUT_HIGH = mode_q == STOP_ST;
  assign O_LCD_FORCE_LOW = in_stop &&
    !ctrl_q[`CTRL_LCD_EN_BIT];
  assign O_RESUME = (mode_q == WAKE_ST) && (wait_q == 16'h0000);
endmodule : pwrmode_ctrl
`default_nettype wire

// ### pwrmode_props.sv
`default_nettype none
module pwrmode_props (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic [1:0] O_MODE,
  input wire pwrmode_pkg::run_en_t O_RUN,
  input wire pwrmode_pkg::port_cfg_t O_PORT,
  input wire logic [12:0] O_PC_HOLD,
  input wire logic O_VCO_PULLDOWN,
  input wire logic O_CP_OE,
  input wire logic O_OSC_IN_PULLDOWN,
  input wire logic O_OSC_OUT_HIGH,
  input wire logic O_LCD_FORCE_LOW,
  input wire logic O_RESUME
);
  timeunit 1ns;
  timeprecision 1ns;
  import pwrmode_pkg::*;
  // ************************************************************
  // Mode checks
  // ************************************************************
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  wire halt = O_MODE == 2'h1;
  wire stop = O_MODE == 2'h2;
  AST_HALT_RUN: assert property (
    halt |-> !O_RUN.cpu_run && O_RUN.periph_run && O_RUN.lcd_run
      && !O_LCD_FORCE_LOW) else $error("halt run enables wrong");
  AST_STOP_OFF: assert property (
    stop |-> !O_RUN.periph_run && !O_RUN.lcd_run && !O_RUN.pll_run
      && !O_RUN.cpu_run) else $error("stop left a unit running");
  AST_PC_FREEZE: assert property (
    (halt && $past(halt)) || (stop && $past(stop)) |-> $stable(O_PC_HOLD))
    else $error("held pc moved");
  AST_STOP_MUX: assert property (
    stop |-> O_PORT.mux_sel == 4'h0) else $error("pins not in port mode");
  AST_STOP_KEEP: assert property (
    stop |-> $stable(O_PORT.dir) && $stable(O_PORT.latch))
    else $error("pin direction or latch changed in stop");
  AST_PLL_OFF: assert property (
    !O_RUN.pll_run |-> O_VCO_PULLDOWN && !O_CP_OE)
    else $error("pll pins wrong while disabled");
  AST_OSC: assert property (
    stop |-> O_OSC_IN_PULLDOWN && O_OSC_OUT_HIGH)
    else $error("oscillator pins wrong in stop");
  AST_LCD_LOW: assert property (
    stop |-> O_LCD_FORCE_LOW) else $error("lcd not forced low in stop");
  AST_RESUME: assert property (
    O_RESUME |-> O_MODE == 2'h3 ##1 O_MODE == 2'h0)
    else $error("resume outside wake");
endmodule : pwrmode_props
bind pwrmode_ctrl pwrmode_props u_props (.I_MCLK, .I_RSTN, .O_MODE,
  .O_RUN, .O_PORT, .O_PC_HOLD, .O_VCO_PULLDOWN, .O_CP_OE,
  .O_OSC_IN_PULLDOWN, .O_OSC_OUT_HIGH, .O_LCD_FORCE_LOW, .O_RESUME);
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pwrmode_pkg::*;
  logic I_MCLK, I_RSTN, I_WE, I_CYC, I_STB, O_ACK, I_HALT_REQ;
  logic I_HALT_RELEASE, O_VCO_PULLDOWN, O_CP_OE, O_OSC_IN_PULLDOWN;
  logic O_OSC_OUT_HIGH, O_LCD_FORCE_LOW, O_RESUME;
  logic [7:0] I_ADR;
  logic [31:0] I_DAT, O_DAT, rd;
  logic [3:0] I_SEL, I_STOP_MASK, I_WAKE_COND, I_WAKE_INPUT_PORT;
  logic [12:0] I_PC, O_PC_HOLD, pc;
  logic [11:0] pcfg;
  logic [1:0] O_MODE;
  run_en_t O_RUN;
  port_cfg_t O_PORT;
  int error_cnt, n_tests, tick, seed, k;
  pwrmode_ctrl DUT (.I_MCLK, .I_RSTN, .I_ADR, .I_DAT, .O_DAT, .I_WE,
    .I_SEL, .I_CYC, .I_STB, .O_ACK, .I_HALT_REQ, .I_HALT_RELEASE,
    .I_STOP_MASK, .I_WAKE_COND, .I_WAKE_INPUT_PORT, .I_PC, .O_PC_HOLD,
    .O_RUN, .O_PORT, .O_MODE, .O_VCO_PULLDOWN, .O_CP_OE,
    .O_OSC_IN_PULLDOWN, .O_OSC_OUT_HIGH, .O_LCD_FORCE_LOW, .O_RESUME);
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge I_MCLK);
  endtask : step
  // Waits on ack with no fixed latency; the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge I_MCLK);
    {I_CYC, I_STB, I_WE, I_ADR, I_DAT} <= {2'h3, w, a, d};
    do @(posedge I_MCLK); while (O_ACK !== 1'b1);
    q = O_DAT;
    {I_CYC, I_STB} <= 2'h0;
  endtask : wb
  function automatic logic [31:0] keep_ctrl(input logic [31:0] c);
    return c & 32'h2;
  endfunction : keep_ctrl
  initial begin
    I_MCLK = 0;
    forever #50 I_MCLK = ~I_MCLK;
  end
  initial begin
    tick = 0;
    forever begin
      @(posedge I_MCLK);
      tick++;
      if (tick == 6000) begin
        error_cnt++;
        end_of_test();
      end
    end
  end
  initial begin
    seed = 25268;
    {I_RSTN, I_WE, I_CYC, I_STB, I_HALT_REQ, I_HALT_RELEASE} = 6'h0;
    {I_ADR, I_DAT, I_STOP_MASK, I_WAKE_COND, I_WAKE_INPUT_PORT} = 0;
    I_SEL = 4'hF;
    I_PC = 13'h0;
    step(6);
    I_RSTN <= 1'b1;
    @(negedge I_MCLK);
    chk({O_MODE, O_VCO_PULLDOWN, O_CP_OE}, 32'h2);
    pcfg = 12'($random(seed));
    wb(1'b1, 8'h10, {20'h0, pcfg}, rd);
    wb(1'b1, 8'h0C, 32'h4, rd);
    wb(1'b1, 8'h3C, 32'hFF, rd);
    wb(1'b0, 8'h3C, 32'h0, rd);
    chk(rd, 32'h0);
    $display("register test done");
    // Second pass halts with the display off: drive must keep running
    for (k = 0; k < 2; k++) begin
      wb(1'b1, 8'h00, {29'h0, 1'b1, k[0], ~k[0]}, rd);
      pc = 13'($random(seed));
      I_PC <= pc;
      I_HALT_REQ <= 1'b1;
      @(posedge I_MCLK);
      {I_HALT_REQ, I_PC} <= {1'b0, ~pc};
      step(2);
      @(negedge I_MCLK);
      chk({O_MODE, O_CP_OE}, 32'h3);
      chk(O_PC_HOLD, pc);
      chk(O_RUN.sio_run, k);
      chk({O_RUN, O_LCD_FORCE_LOW}, {2'h1, k[0], 2'h3, 1'b0});
      wb(1'b0, 8'h00, 32'h0, rd);
      chk(rd, {29'h0, 1'b1, k[0], ~k[0]});
      I_HALT_RELEASE <= 1'b1;
      @(posedge I_MCLK);
      I_HALT_RELEASE <= 1'b0;
      step(2);
      @(negedge I_MCLK);
      chk(O_MODE, 32'h0);
      $display("halt test %0d done", k);
    end
    pc = 13'($random(seed));
    I_PC <= pc;
    wb(1'b1, 8'h08, 32'h11, rd);
    step(1);
    @(negedge I_MCLK);
    chk(O_MODE, 32'h2);
    chk(O_PORT, {pcfg[11:4], 4'h0});
    chk(O_PC_HOLD, pc);
    chk({O_OSC_IN_PULLDOWN, O_OSC_OUT_HIGH, O_LCD_FORCE_LOW},
      32'h7);
    chk({O_RUN, O_VCO_PULLDOWN, O_CP_OE}, 32'h2);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd, 32'h2);
    @(posedge I_MCLK);
    I_WAKE_INPUT_PORT <= 4'h1;
    k = 0;
    while (O_RESUME !== 1'b1) begin
      @(posedge I_MCLK);
      k++;
    end
    chk(k >= 4 && k <= 8, 32'h1);
    I_WAKE_INPUT_PORT <= 4'h0;
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, keep_ctrl(32'h6));
    $display("stop wake test done");
    wb(1'b1, 8'h08, 32'h10, rd);
    // Zero mask ignores the pin and every core condition alike
    {I_WAKE_COND, I_WAKE_INPUT_PORT} <= 8'hFF;
    step(20);
    @(negedge I_MCLK);
    chk(O_MODE, 32'h2);
    I_RSTN <= 1'b0;
    step(2);
    {I_RSTN, I_WAKE_COND, I_WAKE_INPUT_PORT} <= 9'h100;
    @(negedge I_MCLK);
    chk(O_MODE, 32'h0);
    $display("zero mask test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
